/* tb/sadma_asserts.sv */
/*
  Port checker for one channel.
  Assumes bind to sadma_channel; reset low, one clock.
*/
`timescale 1ns/1ps
module sadma_asserts
  import sadma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0] timer_match_req,
  input wire logic serial_tx_empty_req,
  input wire logic serial_rx_full_req,
  input wire logic ext_req_pin,
  input wire logic xfer_valid,
  input wire sadma_cmd_t xfer_cmd,
  input wire logic xfer_done,
  input wire logic irq
);
  logic req_any;
  assign req_any = (|timer_match_req) | serial_tx_empty_req | serial_rx_full_req | ext_req_pin;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  rdata_quiet_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  cmd_hold_a: assert property (xfer_valid && !xfer_done |=> xfer_valid && $stable(xfer_cmd))
    else $error("command changed early");
  valid_gap_a: assert property (xfer_done |=> !xfer_valid)
    else $error("no gap after done");
  valid_cause_a: assert property ($rose(xfer_valid) |-> $past(req_any))
    else $error("command without request");
  periph_high_a: assert property (xfer_valid |-> xfer_cmd.src_addr[23:8] == 16'hFFFF ||
    xfer_cmd.dst_addr[23:8] == 16'hFFFF)
    else $error("peripheral address high part");
  irq_rise_a: assert property ($rose(irq) |-> $past(xfer_done || reg_write || req_any))
    else $error("interrupt without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_write))
    else $error("interrupt dropped");
  reset_quiet_a: assert property ($rose(reset_n) |-> !xfer_valid && !irq && xfer_cmd == '0)
    else $error("outputs busy after reset");
  cover property ($rose(irq));
  cover property (xfer_valid && xfer_done);
  cover property ($fell(irq));
endmodule

bind sadma_channel sadma_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .timer_match_req(timer_match_req), .serial_tx_empty_req(serial_tx_empty_req),
  .serial_rx_full_req(serial_rx_full_req), .ext_req_pin(ext_req_pin),
  .xfer_valid(xfer_valid), .xfer_cmd(xfer_cmd), .xfer_done(xfer_done), .irq(irq));

/* tb/sadma_bus_model.sv */
/*
  System bus memory model: answers each command lat+1 cycles after xfer_valid rises.
  Assumes xfer_valid holds until xfer_done.
*/
`timescale 1ns/1ps
module sadma_bus_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic xfer_valid,
  input wire logic [3:0] lat,
  output logic xfer_done
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !xfer_valid || xfer_done) begin
      wait_cnt <= 4'h0;
      xfer_done <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      xfer_done <= (wait_cnt == lat);
    end
  end
endmodule

/* tb/testbench.sv */
/*
  Self-checking bench of one channel, idle and repeat mode.
  Assumes the bus model answers commands; checker bound to the channel.
*/
`timescale 1ns/1ps
module testbench
  import sadma_pkg::*;
;
  logic clk_sys, reset_n, reg_write, reg_read, irq, xfer_valid, xfer_done;
  logic serial_tx_empty_req, serial_rx_full_req, ext_req_pin;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] timer_match_req, lat;
  sadma_cmd_t xfer_cmd, cmd_seen;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  sadma_channel dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer_match_req(timer_match_req),
    .serial_tx_empty_req(serial_tx_empty_req), .serial_rx_full_req(serial_rx_full_req),
    .ext_req_pin(ext_req_pin), .xfer_valid(xfer_valid), .xfer_cmd(xfer_cmd),
    .xfer_done(xfer_done), .irq(irq));
  sadma_bus_model mem (.clk_sys(clk_sys), .reset_n(reset_n), .xfer_valid(xfer_valid),
    .lat(lat), .xfer_done(xfer_done));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask
  // one request from source src; exp_v says whether a command must follow
  task automatic fire(input logic [2:0] src, input logic exp_v);
    @(posedge clk_sys);
    timer_match_req <= (src < 3'h4) ? 4'h1 << src[1:0] : 4'h0;
    serial_tx_empty_req <= (src == 3'h4);
    serial_rx_full_req <= (src == 3'h5);
    ext_req_pin <= (src == 3'h6);
    @(posedge clk_sys);
    timer_match_req <= 4'h0;
    serial_tx_empty_req <= 1'b0;
    serial_rx_full_req <= 1'b0;
    #1;
    for (int i = 0; i < 8 && xfer_valid !== 1'b1; i++) @(posedge clk_sys) #1;
    chk("valid", 32'(xfer_valid), 32'(exp_v));
    cmd_seen = xfer_cmd;
    for (int i = 0; i < 12 && xfer_valid === 1'b1; i++) @(posedge clk_sys) #1;
    ext_req_pin <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_regs;
    rchk("mem rst", 8'h00, 32'h0);
    rchk("ctrl rst", 8'h0C, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rchk("mem width", 8'h00, 32'h00FFFFFF);
    wr(8'h18, 32'h5);
    rchk("unmapped", 8'h18, 32'h0);
  endtask
  task automatic t_idle;
    wr(8'h00, 32'h123456);
    wr(8'h04, 32'h42);
    wr(8'h08, 32'h2);
    wr(8'h14, 32'h1);
    wr(8'h0C, 32'h01);
    fire(3'h0, 1'b1);
    chk("src", 32'(cmd_seen.src_addr), 32'h123456);
    chk("dst", 32'(cmd_seen.dst_addr), 32'hFFFF42);
    rchk("count", 8'h08, 32'h1);
    chk("irq early", 32'(irq), 32'h0);
    fire(3'h0, 1'b1);
    chk("src fixed", 32'(cmd_seen.src_addr), 32'h123456);
    rchk("enable off", 8'h0C, 32'h0);
    chk("irq", 32'(irq), 32'h1);
    fire(3'h0, 1'b0);
    wr(8'h14, 32'h0);
    #1 chk("irq masked", 32'(irq), 32'h0);
    wr(8'h10, 32'h1);
    rchk("status clr", 8'h10, 32'h0);
  endtask
  task automatic t_sources;
    wr(8'h08, 32'h0);
    for (int k = 0; k < 7; k++) begin
      wr(8'h0C, {25'h0, 3'(k), 4'h1});
      fire(3'(k), 1'b1);
      chk("dir", 32'(cmd_seen.src_addr), (k == 5) ? 32'hFFFF42 : 32'h123456);
    end
    rchk("count wrap", 8'h08, 32'hFFF9);
    rchk("still on", 8'h0C, 32'h61);
  endtask
  task automatic t_repeat(input logic sz, input logic dn);
    logic [23:0] a;
    logic [23:0] b;
    b = dn ? 24'hFF - 24'(sz) : 24'h101 + 24'(sz);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h100);
    wr(8'h08, 32'h0202);
    wr(8'h0C, {25'h0, 3'h5, dn, sz, 2'h3});
    for (int k = 0; k < 5; k++) begin
      a = k[0] ? b : 24'h100;
      fire(3'h5, 1'b1);
      chk("rpt dst", 32'(cmd_seen.dst_addr), 32'(a));
      chk("rpt size", 32'(cmd_seen.word), 32'(sz));
      chk("rpt irq", 32'(irq), 32'h0);
    end
    wr(8'h0C, {25'h0, 3'h5, dn, sz, 2'h2});
    fire(3'h5, 1'b0);
    rchk("rpt hold", 8'h08, 32'h0102);
    wr(8'h0C, {25'h0, 3'h5, dn, sz, 2'h3});
    fire(3'h5, 1'b1);
    chk("resume", 32'(cmd_seen.dst_addr), 32'(b));
    rchk("reload", 8'h08, 32'h0202);
    rchk("rpt status", 8'h10, 32'h0);
  endtask
  task automatic t_max;
    wr(8'h00, 32'h200);
    wr(8'h08, 32'hFFFF);
    wr(8'h0C, 32'h03);
    repeat (255) fire(3'h0, 1'b1);
    rchk("max count", 8'h08, 32'hFFFF);
    rchk("max rewind", 8'h00, 32'h200);
  endtask
  // second request while the first is still on the bus is lost
  task automatic t_overrun;
    wr(8'h14, 32'h2);
    wr(8'h08, 32'h5);
    wr(8'h0C, 32'h01);
    repeat (2) begin
      @(posedge clk_sys);
      timer_match_req <= 4'h1;
      @(posedge clk_sys);
      timer_match_req <= 4'h0;
    end
    repeat (6) @(posedge clk_sys);
    #1 chk("ovr irq", 32'(irq), 32'h1);
    rchk("ovr status", 8'h10, 32'h2);
    rchk("ovr count", 8'h08, 32'h4);
    wr(8'h10, 32'h2);
    rchk("ovr clr", 8'h10, 32'h0);
  endtask
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    timer_match_req = 4'h0;
    serial_tx_empty_req = 1'b0;
    serial_rx_full_req = 1'b0;
    ext_req_pin = 1'b0;
    lat = 4'h0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs;
    t_idle;
    t_sources;
    lat <= 4'h3;
    t_repeat(1'b0, 1'b0);
    t_repeat(1'b1, 1'b1);
    t_max;
    t_overrun;
    final_report;
  end
endmodule

/* verilog/sadma_cfg.svh */
/*
  Offsets, field positions, reset values and source codes of the channel.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef SADMA_CFG_SVH
`define SADMA_CFG_SVH

// register offsets, byte addresses on the register port
`define SADMA_OFS_MEM_ADDR 8'h00
`define SADMA_OFS_PERIPH_LOW 8'h04
`define SADMA_OFS_COUNTER 8'h08
`define SADMA_OFS_CONTROL 8'h0C
`define SADMA_OFS_IRQ_STATUS 8'h10
`define SADMA_OFS_IRQ_MASK 8'h14

// channel_control field positions
`define SADMA_CTL_ENABLE_BIT 0
`define SADMA_CTL_MODE_BIT 1
`define SADMA_CTL_SIZE_BIT 2
`define SADMA_CTL_DIR_BIT 3
`define SADMA_CTL_SRC_LSB 4
`define SADMA_CTL_SRC_MSB 6

// interrupt status and mask bit positions
`define SADMA_IRQ_DONE_BIT 0
`define SADMA_IRQ_OVERRUN_BIT 1

// request source codes
`define SADMA_SRC_TIMER0 3'h0
`define SADMA_SRC_TIMER1 3'h1
`define SADMA_SRC_TIMER2 3'h2
`define SADMA_SRC_TIMER3 3'h3
`define SADMA_SRC_TX_EMPTY 3'h4
`define SADMA_SRC_RX_FULL 3'h5
`define SADMA_SRC_EXT 3'h6

// reset values
`define SADMA_RST_MEM_ADDR 24'h000000
`define SADMA_RST_PERIPH_LOW 8'h00
`define SADMA_RST_COUNTER 16'h0000
`define SADMA_RST_CONTROL 7'h00
`define SADMA_RST_IRQ 2'h0

// fixed upper part of the peripheral address
`define SADMA_PERIPH_HIGH 16'hFFFF

`endif

/* verilog/sadma_channel.sv */
/*
  One short-address DMA channel in idle mode or repeat mode, with its
  register port, request selection, bus command and interrupt.
  Assumes timer and serial requests are one-cycle pulses on clk_sys,
  the external request is an asynchronous pin, and the system bus
  answers each command with a one-cycle xfer_done.
*/
// Behaviour
// - idle: one unit per request, then stop
// - mode chosen per channel by own bit
// - receive-full moves peripheral to memory
// - peripheral address ones above register byte
// - idle mode holds both addresses fixed
// - idle count reaches zero: disable, interrupt
// - idle start count zero means 65536
// - timers 0-3, serial, external start transfers
// - repeat restores address and count, continues
// - repeat working count reloads from initial
// - repeat address steps, rewinds by count
// - repeat runs until disabled, resumes state
// - repeat mode raises no done interrupt, only overrun
// - repeat count eight bits, max 255
`timescale 1ns/1ps

`include "sadma_cfg.svh"

module sadma_channel
  import sadma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] timer_match_req,
  input wire logic serial_tx_empty_req,
  input wire logic serial_rx_full_req,
  input wire logic ext_req_pin,
  output logic xfer_valid,
  output sadma_cmd_t xfer_cmd,
  input wire logic xfer_done,
  output logic irq
);

  // picks the selected request line out of all sources
  function automatic logic source_hit(
    input logic [2:0] sel,
    input logic [6:0] lines
  );
    logic hit;
    hit = 1'b0;
    if (sel <= `SADMA_SRC_EXT) begin
      hit = lines[sel];
    end
    return hit;
  endfunction

  // register decode for the write strobes; the read path has its own case
  function automatic logic at_offset(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return addr == ofs;
  endfunction

  logic [23:0] memory_address_reg;
  logic [23:0] memory_address_next;
  logic [7:0] peripheral_address_low_reg;
  logic [15:0] transfer_counter_reg;
  logic [15:0] transfer_counter_next;
  sadma_ctrl_t control_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  sadma_state_t state_reg;
  sadma_cmd_t cmd_reg;
  logic [2:0] ext_sync_reg;

  logic wr_mem;
  logic wr_periph;
  logic wr_counter;
  logic wr_control;
  logic wr_status;
  logic wr_mask;
  logic [6:0] req_lines;
  logic req_hit;
  logic accept;
  logic overrun;
  logic complete;
  logic rx_dir;
  logic [23:0] periph_addr;
  logic [23:0] step;
  logic [23:0] mar_stepped;
  logic [23:0] rewind;
  logic [23:0] mar_reloaded;
  logic [7:0] work_count;
  logic [7:0] init_count;
  logic idle_last;
  logic repeat_last;
  logic idle_finish;
  logic [1:0] irq_set;

  assign wr_mem = reg_write && at_offset(reg_addr, `SADMA_OFS_MEM_ADDR);
  assign wr_periph = reg_write && at_offset(reg_addr, `SADMA_OFS_PERIPH_LOW);
  assign wr_counter = reg_write && at_offset(reg_addr, `SADMA_OFS_COUNTER);
  assign wr_control = reg_write && at_offset(reg_addr, `SADMA_OFS_CONTROL);
  assign wr_status = reg_write && at_offset(reg_addr, `SADMA_OFS_IRQ_STATUS);
  assign wr_mask = reg_write && at_offset(reg_addr, `SADMA_OFS_IRQ_MASK);

  // external request pin: two-flop synchroniser, then edge detect
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ext_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_req_pin};
    end
  end

  assign req_lines = {
    ext_sync_reg[1] && !ext_sync_reg[2],
    serial_rx_full_req,
    serial_tx_empty_req,
    timer_match_req
  };

  assign req_hit = source_hit(control_reg.source, req_lines);

  assign accept = control_reg.channel_enable && req_hit &&
                  (state_reg == SADMA_ST_IDLE);

  // a request that lands while a transfer is still on the bus is lost
  assign overrun = control_reg.channel_enable && req_hit &&
                   (state_reg == SADMA_ST_WAIT);

  assign complete = (state_reg == SADMA_ST_WAIT) && xfer_done;

  assign rx_dir = control_reg.source == `SADMA_SRC_RX_FULL;

  assign periph_addr = {`SADMA_PERIPH_HIGH, peripheral_address_low_reg};

  // sequencer: one bus command per accepted request
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= SADMA_ST_IDLE;
    end else begin
      unique case (state_reg)
        SADMA_ST_IDLE: begin
          if (accept) begin
            state_reg <= SADMA_ST_WAIT;
          end
        end
        SADMA_ST_WAIT: begin
          if (xfer_done) begin
            state_reg <= SADMA_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cmd_reg <= '0;
    end else if (accept) begin
      cmd_reg.word <= control_reg.transfer_size_select;
      if (rx_dir) begin
        cmd_reg.src_addr <= periph_addr;
        cmd_reg.dst_addr <= memory_address_reg;
      end else begin
        cmd_reg.src_addr <= memory_address_reg;
        cmd_reg.dst_addr <= periph_addr;
      end
    end
  end

  assign xfer_valid = state_reg == SADMA_ST_WAIT;
  assign xfer_cmd = cmd_reg;

  // address arithmetic for repeat mode
  assign step = control_reg.transfer_size_select ? 24'h000002 : 24'h000001;
  assign mar_stepped = control_reg.address_direction_select ?
                       memory_address_reg - step :
                       memory_address_reg + step;
  assign init_count = transfer_counter_reg[7:0];
  assign work_count = transfer_counter_reg[15:8];
  assign rewind = control_reg.transfer_size_select ?
                  {15'h0000, init_count, 1'b0} :
                  {16'h0000, init_count};
  assign mar_reloaded = control_reg.address_direction_select ?
                        mar_stepped + rewind :
                        mar_stepped - rewind;

  assign idle_last = transfer_counter_reg == 16'h0001;
  assign repeat_last = work_count == 8'h01;
  assign idle_finish = complete && !control_reg.repeat_mode && idle_last;

  always_comb begin
    memory_address_next = memory_address_reg;
    transfer_counter_next = transfer_counter_reg;
    if (complete) begin
      if (control_reg.repeat_mode) begin
        if (repeat_last) begin
          memory_address_next = mar_reloaded;
          transfer_counter_next = {init_count, init_count};
        end else begin
          memory_address_next = mar_stepped;
          transfer_counter_next = {work_count - 8'h01, init_count};
        end
      end else begin
        // zero start wraps through FFFF, giving the full 65536
        transfer_counter_next = transfer_counter_reg - 16'h0001;
        memory_address_next = memory_address_reg;
      end
    end else if (wr_counter) begin
      transfer_counter_next = reg_wdata[15:0];
    end else if (wr_mem) begin
      memory_address_next = reg_wdata[23:0];
    end
    if (complete && wr_counter) begin
      transfer_counter_next = transfer_counter_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      memory_address_reg <= `SADMA_RST_MEM_ADDR;
    end else begin
      memory_address_reg <= memory_address_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      transfer_counter_reg <= `SADMA_RST_COUNTER;
    end else begin
      transfer_counter_reg <= transfer_counter_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      peripheral_address_low_reg <= `SADMA_RST_PERIPH_LOW;
    end else if (wr_periph) begin
      peripheral_address_low_reg <= reg_wdata[7:0];
    end
  end

  // control: software writes, hardware clears enable at idle end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      control_reg <= `SADMA_RST_CONTROL;
    end else begin
      if (wr_control) begin
        control_reg <= reg_wdata[`SADMA_CTL_SRC_MSB:0];
      end
      if (idle_finish) begin
        control_reg.channel_enable <= 1'b0;
      end
    end
  end

  // repeat mode raises no done event
  assign irq_set = {overrun, idle_finish};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_status_reg <= `SADMA_RST_IRQ;
    end else if (wr_status) begin
      irq_status_reg <= (irq_status_reg & ~reg_wdata[1:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_mask_reg <= `SADMA_RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
    end else if (!reg_read) begin
      rdata_reg <= 32'h00000000;
    end else begin
      unique case (reg_addr)
        `SADMA_OFS_MEM_ADDR: rdata_reg <= {8'h00, memory_address_reg};
        `SADMA_OFS_PERIPH_LOW: rdata_reg <= {24'h000000, peripheral_address_low_reg};
        `SADMA_OFS_COUNTER: rdata_reg <= {16'h0000, transfer_counter_reg};
        `SADMA_OFS_CONTROL: rdata_reg <= {25'h0000000, control_reg};
        `SADMA_OFS_IRQ_STATUS: rdata_reg <= {30'h00000000, irq_status_reg};
        `SADMA_OFS_IRQ_MASK: rdata_reg <= {30'h00000000, irq_mask_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

/* verilog/sadma_pkg.sv */
/*
  Types of the short-address DMA channel: sequencer states, control
  word layout and the transfer command handed to the system bus.
  Assumes sadma_cfg.svh for the field positions it mirrors.
*/
package sadma_pkg;

  typedef enum logic [0:0] {
    SADMA_ST_IDLE,
    SADMA_ST_WAIT
  } sadma_state_t;

  // bit order matches the channel_control field positions
  typedef struct packed {
    logic [2:0] source;
    logic address_direction_select;
    logic transfer_size_select;
    logic repeat_mode;
    logic channel_enable;
  } sadma_ctrl_t;

  typedef struct packed {
    logic [23:0] src_addr;
    logic [23:0] dst_addr;
    logic word;
  } sadma_cmd_t;

endpackage
